// >>> hw/tmc_defs.svh
// register indices, field positions, reset values and codes of the timer/counter
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// register indices; byte address is four times the index
`define TMC_IDX_FLAGS     10'h00c
`define TMC_IDX_CLEAR     10'h00d
`define TMC_IDX_CNT_LO    10'h00e
`define TMC_IDX_CNT_HI    10'h00f
`define TMC_IDX_CTRL      10'h010
`define TMC_IDX_CMP_LO    10'h015
`define TMC_IDX_CMP_HI    10'h016
`define TMC_IDX_CMP_MODE  10'h017
`define TMC_IDX_ENABLES   10'h08c

// counter_control fields
`define TMC_CTRL_RUN      0
`define TMC_CTRL_SRC      1
`define TMC_CTRL_SYNC     2
`define TMC_CTRL_OSC      3
`define TMC_CTRL_PS_LO    4
`define TMC_CTRL_PS_HI    5

// flag and enable fields
`define TMC_FLAG_OVF      0
`define TMC_EN_OVF        0

// reset values
`define TMC_CTRL_RST      6'h00
`define TMC_FLAGS_RST     1'h0
`define TMC_EN_RST        1'h0
`define TMC_CNT_RST       16'h0000
`define TMC_CMP_RST       16'h0000
`define TMC_CMP_MODE_RST  4'h0

// codes
`define TMC_CMP_SPECIAL   4'hb
`define TMC_CNT_MAX       16'hffff
`define TMC_RESP_OKAY     2'h0
`define TMC_RESP_SLVERR   2'h2

`endif

// >>> hw/tmc_pkg.sv
// types shared by the timer/counter design
package tmc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ARM     = 4'h2,
		ST_RUN_INT = 4'h4,
		ST_RUN_EXT = 4'h8
	} tmc_state_t;
endpackage

// >>> hw/tmc_prescale.sv
// divide-by-1/2/4/8 prescaler on the count increment
`timescale 1ns/1ps
module tmc_prescale
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       clear,
	input  wire logic [1:0] div_code,
	input  wire logic       inc_in,
	// result
	output logic            tick
);
	logic [2:0] pcnt_reg, pcnt_next;
	logic [2:0] limit;

	always_comb begin
		case (div_code)
			2'h0: limit = 3'h0;
			2'h1: limit = 3'h1;
			2'h2: limit = 3'h3;
			default: limit = 3'h7;
		endcase
		tick = inc_in & (pcnt_reg >= limit);
		pcnt_next = pcnt_reg;
		if (clear) begin
			pcnt_next = 3'h0;
		end else if (tick) begin
			pcnt_next = 3'h0;
		end else if (inc_in) begin
			pcnt_next = pcnt_reg + 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcnt_reg <= 3'h0;
		end else begin
			pcnt_reg <= pcnt_next;
		end
	end
endmodule // tmc_prescale

// >>> hw/tmc_sync.sv
// external count input synchroniser and edge finder
`timescale 1ns/1ps
module tmc_sync
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// pin and mode
	input  wire logic pin_in,
	input  wire logic bypass,
	// edges
	output logic      rise,
	output logic      fall
);
	logic s1_reg, s2_reg, s3_reg, prev_reg;
	logic s1_next, s2_next, s3_next, prev_next;
	logic sel;

	always_comb begin
		s1_next = pin_in;
		s2_next = s1_reg;
		s3_next = s2_reg;
		// bypass skips the retiming stage
		sel = bypass ? s2_reg : s3_reg;
		prev_next = sel;
		rise = sel & ~prev_reg;
		fall = ~sel & prev_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg   <= 1'b0;
			s2_reg   <= 1'b0;
			s3_reg   <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			s1_reg   <= s1_next;
			s2_reg   <= s2_next;
			s3_reg   <= s3_next;
			prev_reg <= prev_next;
		end
	end
endmodule // tmc_sync

// >>> hw/tmc_top.sv
// sixteen-bit timer/counter with AXI4-Lite register slave
// Function
// - count is 16 bits as two read/write bytes, low and high
// - control bit 0 starts counting when set, halts when clear
// - bit 1 picks source: 0 instruction cycle, 1 external rising edges
// - external mode needs a falling edge before rising edges count
// - modes: internal timer, synchronised counter, asynchronous counter
// - bit 3 powers the crystal oscillator amplifier and feedback
// - oscillator enabled takes both pins from GPIO; direction ignored
// - oscillator and external counting keep running in sleep
// - count wraps from ffff to 0000, which is the overflow event
// - overflow latches flag bit 0; interrupt only with enable bit 0
// - compare mode 1011 trigger clears count and starts a conversion
// - trigger clear is dependable only in timer or synchronised mode
// - a count write in the trigger cycle wins over the clear
// - in compare mode 1011 the compare pair acts as period; count restarts at zero on match
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_top
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// count sources and system
	input  wire logic        external_count_clock,
	input  wire logic        crystal_in_pin,
	input  wire logic        cpu_sleep,
	input  wire logic        adc_enable,
	input  wire logic [1:0]  port_direction_bits,
	// outputs
	output logic             irq,
	output logic             adc_start,
	output logic             osc_amp_enable,
	output logic [1:0]       osc_pin_oe
);
	// bus state
	logic        aw_held_reg, aw_held_next;
	logic [9:0]  aw_idx_reg, aw_idx_next;
	logic        w_held_reg, w_held_next;
	logic [7:0]  wbyte_reg, wbyte_next;
	logic        wlane_reg, wlane_next;
	logic        awready_reg, awready_next;
	logic        wready_reg, wready_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	// block state
	tmc_state_t  state_reg, state_next;
	logic [5:0]  ctrl_reg, ctrl_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] cmp_reg, cmp_next;
	logic [3:0]  cmode_reg, cmode_next;
	logic        ovf_reg, ovf_next;
	logic        en_reg, en_next;
	logic        irq_reg, irq_next;
	logic        adc_reg, adc_next;
	logic        osc_reg, osc_next;
	logic [1:0]  pin_oe_reg, pin_oe_next;
	// decoded strobes
	logic        do_write, wr_hit, wr_ok;
	logic        wr_clr, wr_lo, wr_hi, wr_ctrl, wr_cmp_lo, wr_cmp_hi, wr_cmode, wr_en;
	logic        wr_cnt;
	logic [9:0]  ar_idx;
	logic [31:0] rd_word;
	logic        rd_hit;
	// count path
	logic        ext_raw, ext_rise, ext_fall;
	logic        inc_src, tick, trig, ovf_set, async_mode;

	assign awready = awready_reg;
	assign wready  = wready_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = arready_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;
	assign irq            = irq_reg;
	assign adc_start      = adc_reg;
	assign osc_amp_enable = osc_reg;
	assign osc_pin_oe     = pin_oe_reg;

	// address decode
	always_comb begin
		do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
		wr_hit = (aw_idx_reg == `TMC_IDX_CLEAR) | (aw_idx_reg == `TMC_IDX_CNT_LO)
			| (aw_idx_reg == `TMC_IDX_CNT_HI) | (aw_idx_reg == `TMC_IDX_CTRL)
			| (aw_idx_reg == `TMC_IDX_CMP_LO) | (aw_idx_reg == `TMC_IDX_CMP_HI)
			| (aw_idx_reg == `TMC_IDX_CMP_MODE) | (aw_idx_reg == `TMC_IDX_ENABLES);
		wr_ok     = do_write & wr_hit & wlane_reg;
		wr_clr    = wr_ok & (aw_idx_reg == `TMC_IDX_CLEAR);
		wr_lo     = wr_ok & (aw_idx_reg == `TMC_IDX_CNT_LO);
		wr_hi     = wr_ok & (aw_idx_reg == `TMC_IDX_CNT_HI);
		wr_ctrl   = wr_ok & (aw_idx_reg == `TMC_IDX_CTRL);
		wr_cmp_lo = wr_ok & (aw_idx_reg == `TMC_IDX_CMP_LO);
		wr_cmp_hi = wr_ok & (aw_idx_reg == `TMC_IDX_CMP_HI);
		wr_cmode  = wr_ok & (aw_idx_reg == `TMC_IDX_CMP_MODE);
		wr_en     = wr_ok & (aw_idx_reg == `TMC_IDX_ENABLES);
		wr_cnt    = wr_lo | wr_hi;
		ar_idx  = araddr[11:2];
		rd_word = 32'h0;
		rd_hit  = 1'b1;
		case (ar_idx)
			`TMC_IDX_FLAGS:    rd_word = {31'h0, ovf_reg};
			`TMC_IDX_CLEAR:    rd_word = 32'h0;
			`TMC_IDX_CNT_LO:   rd_word = {24'h0, cnt_reg[7:0]};
			`TMC_IDX_CNT_HI:   rd_word = {24'h0, cnt_reg[15:8]};
			`TMC_IDX_CTRL:     rd_word = {26'h0, ctrl_reg};
			`TMC_IDX_CMP_LO:   rd_word = {24'h0, cmp_reg[7:0]};
			`TMC_IDX_CMP_HI:   rd_word = {24'h0, cmp_reg[15:8]};
			`TMC_IDX_CMP_MODE: rd_word = {28'h0, cmode_reg};
			`TMC_IDX_ENABLES:  rd_word = {31'h0, en_reg};
			default:           rd_hit = 1'b0;
		endcase
	end

	// bus channels
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_idx_next  = aw_idx_reg;
		w_held_next  = w_held_reg;
		wbyte_next   = wbyte_reg;
		wlane_next   = wlane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (awvalid & awready_reg) begin
			aw_held_next = 1'b1;
			aw_idx_next  = awaddr[11:2];
		end
		if (wvalid & wready_reg) begin
			w_held_next = 1'b1;
			wbyte_next  = wdata[7:0];
			wlane_next  = wstrb[0];
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
		end else if (bvalid_reg & bready) begin
			bvalid_next = 1'b0;
		end
		if (arvalid & arready_reg) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_word;
			rresp_next  = rd_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
		end else if (rvalid_reg & rready) begin
			rvalid_next = 1'b0;
		end
		awready_next = ~aw_held_next & ~bvalid_next;
		wready_next  = ~w_held_next & ~bvalid_next;
		arready_next = ~rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 10'h000;
			w_held_reg  <= 1'b0;
			wbyte_reg   <= 8'h00;
			wlane_reg   <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `TMC_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= `TMC_RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_idx_reg  <= aw_idx_next;
			w_held_reg  <= w_held_next;
			wbyte_reg   <= wbyte_next;
			wlane_reg   <= wlane_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// crystal output replaces the external pin when the oscillator runs
	assign ext_raw = ctrl_reg[`TMC_CTRL_OSC] ? crystal_in_pin : external_count_clock;

	tmc_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  (ext_raw),
		.bypass  (ctrl_reg[`TMC_CTRL_SYNC]),
		.rise    (ext_rise),
		.fall    (ext_fall)
	);

	tmc_prescale u_prescale (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.clear    (~ctrl_reg[`TMC_CTRL_RUN] | wr_cnt),
		.div_code (ctrl_reg[`TMC_CTRL_PS_HI:`TMC_CTRL_PS_LO]),
		.inc_in   (inc_src),
		.tick     (tick)
	);

	// counting
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ctrl_reg[`TMC_CTRL_RUN]) begin
					state_next = ctrl_reg[`TMC_CTRL_SRC] ? ST_ARM : ST_RUN_INT;
				end
			end
			ST_ARM: begin
				if (!ctrl_reg[`TMC_CTRL_RUN]) begin
					state_next = ST_IDLE;
				end else if (!ctrl_reg[`TMC_CTRL_SRC]) begin
					state_next = ST_RUN_INT;
				end else if (ext_fall) begin
					state_next = ST_RUN_EXT;
				end
			end
			ST_RUN_INT: begin
				if (!ctrl_reg[`TMC_CTRL_RUN]) begin
					state_next = ST_IDLE;
				end else if (ctrl_reg[`TMC_CTRL_SRC]) begin
					state_next = ST_ARM;
				end
			end
			ST_RUN_EXT: begin
				if (!ctrl_reg[`TMC_CTRL_RUN]) begin
					state_next = ST_IDLE;
				end else if (!ctrl_reg[`TMC_CTRL_SRC]) begin
					state_next = ST_RUN_INT;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		// internal clock ignores the sync bit and stops in sleep
		// run bit gates at once, before the state follows it
		inc_src = ctrl_reg[`TMC_CTRL_RUN]
			& (((state_reg == ST_RUN_INT) & ~cpu_sleep)
			| ((state_reg == ST_RUN_EXT) & ext_rise));
		async_mode = ctrl_reg[`TMC_CTRL_SRC] & ctrl_reg[`TMC_CTRL_SYNC];
		trig = (cmode_reg == `TMC_CMP_SPECIAL) & (cnt_reg == cmp_reg) & tick
			& ~async_mode;
		ovf_set = tick & ~trig & ~wr_cnt & (cnt_reg == `TMC_CNT_MAX);
		cnt_next = cnt_reg;
		if (wr_cnt) begin
			if (wr_lo) begin
				cnt_next[7:0] = wbyte_reg;
			end
			if (wr_hi) begin
				cnt_next[15:8] = wbyte_reg;
			end
		end else if (trig) begin
			cnt_next = 16'h0000;
		end else if (tick) begin
			cnt_next = cnt_reg + 16'h0001;
		end
		ctrl_next  = wr_ctrl ? wbyte_reg[5:0] : ctrl_reg;
		cmp_next   = cmp_reg;
		if (wr_cmp_lo) begin
			cmp_next[7:0] = wbyte_reg;
		end
		if (wr_cmp_hi) begin
			cmp_next[15:8] = wbyte_reg;
		end
		cmode_next = wr_cmode ? wbyte_reg[3:0] : cmode_reg;
		en_next    = wr_en ? wbyte_reg[`TMC_EN_OVF] : en_reg;
		// set wins over a clear in the same cycle
		ovf_next = ovf_set | (ovf_reg & ~(wr_clr & wbyte_reg[`TMC_FLAG_OVF]));
		irq_next = ovf_reg & en_reg;
		adc_next = trig & adc_enable;
		osc_next = ctrl_reg[`TMC_CTRL_OSC];
		pin_oe_next = ctrl_reg[`TMC_CTRL_OSC] ? 2'h0 : ~port_direction_bits;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg  <= ST_IDLE;
			ctrl_reg   <= `TMC_CTRL_RST;
			cnt_reg    <= `TMC_CNT_RST;
			cmp_reg    <= `TMC_CMP_RST;
			cmode_reg  <= `TMC_CMP_MODE_RST;
			ovf_reg    <= `TMC_FLAGS_RST;
			en_reg     <= `TMC_EN_RST;
			irq_reg    <= 1'b0;
			adc_reg    <= 1'b0;
			osc_reg    <= 1'b0;
			pin_oe_reg <= 2'h0;
		end else begin
			state_reg  <= state_next;
			ctrl_reg   <= ctrl_next;
			cnt_reg    <= cnt_next;
			cmp_reg    <= cmp_next;
			cmode_reg  <= cmode_next;
			ovf_reg    <= ovf_next;
			en_reg     <= en_next;
			irq_reg    <= irq_next;
			adc_reg    <= adc_next;
			osc_reg    <= osc_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_overflow;
		ovf_set |=> ovf_reg && (cnt_reg == 16'h0000);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow lost");

	property p_trig_no_flag;
		trig && !ovf_reg |=> !ovf_reg;
	endproperty
	a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger set flag");

	property p_write_wins;
		trig && wr_lo |=> cnt_reg[7:0] == $past(wbyte_reg);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

	property p_halt;
		!ctrl_reg[`TMC_CTRL_RUN] && !wr_cnt |=> $stable(cnt_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("counted while halted");

	property p_arm;
		(state_reg == ST_ARM) && !wr_cnt |=> $stable(cnt_reg);
	endproperty
	a_arm: assert property (p_arm) else $error("counted before falling edge");

	property p_irq;
		ovf_reg && en_reg |=> irq_reg ##1 (irq_reg || !$past(ovf_reg && en_reg));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");

	property p_irq_masked;
		!en_reg |=> !irq_reg;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");

	property p_internal;
		(state_reg == ST_RUN_INT) && ctrl_reg[`TMC_CTRL_RUN] && !cpu_sleep
			&& (ctrl_reg[5:4] == 2'h0) && !wr_cnt && !trig
			|=> cnt_reg == 16'($past(cnt_reg) + 16'h0001);
	endproperty
	a_internal: assert property (p_internal) else $error("timer missed cycle");

	property p_async_trig;
		async_mode |-> !trig;
	endproperty
	a_async_trig: assert property (p_async_trig) else $error("async trigger");

	logic adc_start_q;
	assign adc_start_q = adc_reg;
	property p_adc;
		trig && adc_enable |=> adc_start_q;
	endproperty
	a_adc: assert property (p_adc) else $error("conversion not started");

	logic [1:0] osc_pin_oe_q;
	assign osc_pin_oe_q = pin_oe_reg;
	property p_osc_pins;
		ctrl_reg[`TMC_CTRL_OSC] |=> osc_pin_oe_q == 2'h0 && osc_reg;
	endproperty
	a_osc_pins: assert property (p_osc_pins) else $error("pins not claimed");

	property p_rhold;
		rvalid_reg && !rready |=> rvalid_reg && $stable(rdata_reg);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule // tmc_top

// >>> tb/test_sixteen_bit_timer_counter.sv
// self-checking bench of the sixteen-bit timer/counter
`timescale 1ns/1ps
`include "tmc_defs.svh"
module test_sixteen_bit_timer_counter;
	logic        aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [2:0]  awprot = 0, arprot = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp_q, osc_pin_oe;
	logic        ext_clk, xtal, irq, adc_start, osc_amp_enable;
	logic        cpu_sleep = 0, adc_enable = 0, f_req = 0, f_xtal = 0, f_done;
	logic [1:0]  port_direction_bits = 2'h1;
	logic [7:0]  f_tog = 0;
	int          err_total = 0, checks_done = 0, cyc = 0, adc_n = 0;

	tmc_top i_tmc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .external_count_clock(ext_clk), .crystal_in_pin(xtal),
		.cpu_sleep(cpu_sleep), .adc_enable(adc_enable),
		.port_direction_bits(port_direction_bits), .irq(irq), .adc_start(adc_start),
		.osc_amp_enable(osc_amp_enable), .osc_pin_oe(osc_pin_oe));
	tmc_far_model i_tmc_far_model (.req(f_req), .toggles(f_tog), .use_xtal(f_xtal),
		.done(f_done), .ext_clk(ext_clk), .xtal(xtal));

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (adc_start === 1'b1)
			adc_n <= adc_n + 1;
		if (cyc == 60000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp_q = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] idx, output logic [31:0] d);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp_q = rresp;
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		rd(idx, d);
		check(d, exp);
	endtask

	task automatic zero_count;
		wr(`TMC_IDX_CNT_LO, 8'h00);
		wr(`TMC_IDX_CNT_HI, 8'h00);
	endtask

	// n pin transitions from the far side, then let the sync path settle
	task automatic burst(input logic [7:0] n, input logic x);
		@(posedge aclk);
		f_tog <= n;
		f_xtal <= x;
		f_req <= 1'b1;
		do @(posedge aclk); while (f_done !== 1'b1);
		f_req <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask

	task automatic t_reset;
		rc(`TMC_IDX_CTRL, 32'h0);
		rc(`TMC_IDX_FLAGS, 32'h0);
		rc(`TMC_IDX_ENABLES, 32'h0);
		rc(10'h3ff, 32'h0);
		check(resp_q, `TMC_RESP_SLVERR);
		wr(`TMC_IDX_CNT_LO, 8'h5a);
		check(resp_q, `TMC_RESP_OKAY);
		wr(`TMC_IDX_CNT_HI, 8'ha5);
		rc(`TMC_IDX_CNT_LO, 32'h5a);
		rc(`TMC_IDX_CNT_HI, 32'ha5);
		$display("test reset and halves done");
	endtask

	task automatic t_prescale;
		int t0, e;
		logic [31:0] d, d2;
		for (int ps = 0; ps < 4; ps++) begin
			zero_count();
			wr(`TMC_IDX_CTRL, {ps[1:0], 4'b0101});
			t0 = cyc;
			repeat (64) @(posedge aclk);
			wr(`TMC_IDX_CTRL, 8'h00);
			e = (cyc - t0) >> ps;
			rd(`TMC_IDX_CNT_LO, d);
			check(32'(d >= e - 2 && d <= e + 2), 32'h1);
			repeat (20) @(posedge aclk);
			rd(`TMC_IDX_CNT_LO, d2);
			check(d2, d);
		end
		cpu_sleep <= 1'b1;
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h01);
		repeat (30) @(posedge aclk);
		rc(`TMC_IDX_CNT_LO, 32'h0);
		wr(`TMC_IDX_CTRL, 8'h00);
		cpu_sleep <= 1'b0;
		$display("test prescale done");
	endtask

	task automatic t_ext;
		for (int sy = 0; sy < 2; sy++) begin
			zero_count();
			wr(`TMC_IDX_CTRL, {5'h0, sy[0], 2'b11});
			burst(10, 1'b0);
			rc(`TMC_IDX_CNT_LO, 32'h5);
			cpu_sleep <= 1'b1;
			burst(4, 1'b0);
			rc(`TMC_IDX_CNT_LO, 32'h7);
			cpu_sleep <= 1'b0;
		end
		wr(`TMC_IDX_CTRL, 8'h00);
		burst(1, 1'b0);
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h03);
		burst(6, 1'b0);
		rc(`TMC_IDX_CNT_LO, 32'h2);
		burst(1, 1'b0);
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h23);
		burst(16, 1'b0);
		rc(`TMC_IDX_CNT_LO, 32'h2);
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h0b);
		repeat (50) @(posedge aclk);
		check(osc_amp_enable, 1'b1);
		check(osc_pin_oe, 2'b00);
		burst(6, 1'b1);
		rc(`TMC_IDX_CNT_LO, 32'h3);
		wr(`TMC_IDX_CTRL, 8'h00);
		repeat (3) @(posedge aclk);
		check(osc_amp_enable, 1'b0);
		check(osc_pin_oe, 2'b10);
		$display("test external done");
	endtask

	task automatic t_ovf;
		wr(`TMC_IDX_CNT_LO, 8'hf0);
		wr(`TMC_IDX_CNT_HI, 8'hff);
		wr(`TMC_IDX_CTRL, 8'h01);
		repeat (40) @(posedge aclk);
		wr(`TMC_IDX_CTRL, 8'h00);
		rc(`TMC_IDX_FLAGS, 32'h1);
		rc(`TMC_IDX_CNT_HI, 32'h0);
		check(irq, 1'b0);
		wr(`TMC_IDX_ENABLES, 8'h01);
		repeat (3) @(posedge aclk);
		check(irq, 1'b1);
		wr(`TMC_IDX_CLEAR, 8'h01);
		repeat (3) @(posedge aclk);
		check(irq, 1'b0);
		rc(`TMC_IDX_FLAGS, 32'h0);
		$display("test overflow done");
	endtask

	task automatic t_trig;
		int c1, n0;
		zero_count();
		wr(`TMC_IDX_CMP_LO, 8'h10);
		wr(`TMC_IDX_CMP_HI, 8'h00);
		wr(`TMC_IDX_CMP_MODE, 8'h0b);
		adc_enable <= 1'b1;
		wr(`TMC_IDX_CTRL, 8'h01);
		do @(posedge aclk); while (adc_start !== 1'b1);
		c1 = cyc;
		do @(posedge aclk); while (adc_start !== 1'b1);
		check(cyc - c1, 32'd17);
		wr(`TMC_IDX_CTRL, 8'h00);
		rc(`TMC_IDX_FLAGS, 32'h0);
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h07);
		n0 = adc_n;
		burst(40, 1'b0);
		check(adc_n - n0, 32'd0);
		rc(`TMC_IDX_CNT_LO, 32'h14);
		zero_count();
		wr(`TMC_IDX_CTRL, 8'h03);
		n0 = adc_n;
		burst(40, 1'b0);
		check(adc_n - n0, 32'd1);
		rc(`TMC_IDX_CNT_LO, 32'h3);
		wr(`TMC_IDX_CTRL, 8'h00);
		$display("test trigger done");
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_prescale();
		t_ext();
		t_ovf();
		t_trig();
		print_verdict();
	end
endmodule // test_sixteen_bit_timer_counter

// >>> tb/tmc_far_model.sv
// far-side count source: external clock pin or crystal, toggled in bursts
`timescale 1ns/1ps
module tmc_far_model (
	// request
	input  wire logic       req,
	input  wire logic [7:0] toggles,
	input  wire logic       use_xtal,
	output logic            done,
	// pins
	output logic            ext_clk,
	output logic            xtal
);
	// pins stand still between bursts; 40 ns per level gives an 80 ns period
	initial begin
		done = 1'b0;
		ext_clk = 1'b1;
		xtal = 1'b1;
		forever begin
			wait (req);
			#3;
			for (int i = 0; i < toggles; i++) begin
				if (use_xtal)
					xtal = ~xtal;
				else
					ext_clk = ~ext_clk;
				#40;
			end
			done = 1'b1;
			wait (!req);
			done = 1'b0;
		end
	end
endmodule // tmc_far_model
